// ==== core/ofd_pkg.sv ====
package ofd_pkg;

	// Widths of the data path
	localparam int OFD_ADDR_W = 8;
	localparam int OFD_DATA_W = 32;
	localparam int OFD_CODE_W = 22;
	localparam int OFD_WORD_W = 24;
	localparam int OFD_MAG_W = 4;
	localparam int OFD_PHASES = 4;
	localparam int OFD_EVT_W = 6;
	localparam int OFD_CNT_W = 16;

	// Register byte offsets
	localparam logic [7:0] OFD_CTRL_OFS = 8'h00;
	localparam logic [7:0] OFD_STATUS_OFS = 8'h04;
	localparam logic [7:0] OFD_INT_STATUS_OFS = 8'h08;
	localparam logic [7:0] OFD_INT_CLEAR_OFS = 8'h0C;
	localparam logic [7:0] OFD_INT_ENABLE_OFS = 8'h10;
	localparam logic [7:0] OFD_CYCLES_OFS = 8'h14;
	localparam logic [3:0] OFD_OFFSET_PAGE = 4'h2;
	localparam logic [3:0] OFD_RESULT_PAGE = 4'h4;

	// Field positions
	localparam int OFD_CTRL_THREE_LED_BIT = 0;
	localparam int OFD_OFS_MAG_LSB = 0;
	localparam int OFD_OFS_POL_BIT = 8;
	localparam int OFD_STATUS_PHASE_LSB = 0;
	localparam int OFD_STATUS_KIND_LSB = 4;
	localparam int OFD_STATUS_MODE_BIT = 8;
	localparam int OFD_EVT_RES_LSB = 0;
	localparam int OFD_EVT_OVER_BIT = 4;
	localparam int OFD_EVT_UNDER_BIT = 5;
	localparam int OFD_RANGE_LSB = 21;

	// Values after reset
	localparam logic [OFD_MAG_W-1:0] OFD_MAG_RST = 4'h0;
	localparam logic OFD_POL_RST = 1'b0;
	localparam logic [OFD_WORD_W-1:0] OFD_RESULT_RST = 24'h000000;
	localparam logic [OFD_EVT_W-1:0] OFD_EVT_RST = 6'h00;
	localparam logic [OFD_CNT_W-1:0] OFD_CNT_RST = 16'h0000;

	// Range codes in bits 23..21 and the clipped words
	localparam logic [2:0] OFD_RANGE_POS = 3'h0;
	localparam logic [2:0] OFD_RANGE_NEG = 3'h7;
	localparam logic [2:0] OFD_RANGE_OVER = 3'h1;
	localparam logic [2:0] OFD_RANGE_UNDER = 3'h6;
	localparam logic [OFD_WORD_W-1:0] OFD_OVER_WORD = 24'h3FFFFF;
	localparam logic [OFD_WORD_W-1:0] OFD_UNDER_WORD = 24'hC00000;

	localparam logic [1:0] OFD_RESP_OKAY = 2'h0;
	localparam logic [1:0] OFD_RESP_SLVERR = 2'h2;

	// Sampling phase, Gray coded along the sequence
	typedef enum logic [1:0] {
		OFD_PH_LED2 = 2'h0,
		OFD_PH_MID = 2'h1,
		OFD_PH_LED1 = 2'h3,
		OFD_PH_AMB1 = 2'h2
	} ofd_phase_t;

	// What the photodiode sees in the active phase
	typedef enum logic [2:0] {
		OFD_KIND_LED2 = 3'h0,
		OFD_KIND_AMB2 = 3'h1,
		OFD_KIND_LED3 = 3'h2,
		OFD_KIND_LED1 = 3'h3,
		OFD_KIND_AMB1 = 3'h4
	} ofd_kind_t;

	typedef enum logic [2:0] {
		OFD_SEL_CTRL,
		OFD_SEL_STATUS,
		OFD_SEL_ISTAT,
		OFD_SEL_ICLR,
		OFD_SEL_IEN,
		OFD_SEL_CYCLES,
		OFD_SEL_OFFSET,
		OFD_SEL_RESULT
	} ofd_sel_t;

endpackage

// ==== core/ofd_conv_if.sv ====
`timescale 1ns/1ps
interface ofd_conv_if;
	import ofd_pkg::*;

	logic in_valid;
	logic [1:0] in_phase;
	logic [OFD_CODE_W-1:0] in_code;
	logic in_over;
	logic in_under;
	logic out_valid;
	logic [1:0] out_phase;
	logic [OFD_WORD_W-1:0] out_word;

	modport fmt (
		input in_valid,
		input in_phase,
		input in_code,
		input in_over,
		input in_under,
		output out_valid,
		output out_phase,
		output out_word
	);

	modport core (
		output in_valid,
		output in_phase,
		output in_code,
		output in_over,
		output in_under,
		input out_valid,
		input out_phase,
		input out_word
	);

endinterface

// ==== core/ofd_fmt.sv ====
`timescale 1ns/1ps
module ofd_fmt (
	input wire logic clk_sys,
	input wire logic reset_n,
	ofd_conv_if.fmt conv
);
	import ofd_pkg::*;

	typedef struct packed {
		logic valid;
		logic [1:0] phase;
		logic [OFD_WORD_W-1:0] word;
	} ofd_fmt_state_t;

	ofd_fmt_state_t st_reg;
	ofd_fmt_state_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.valid = conv.in_valid;
		if (conv.in_valid) begin
			st_next.phase = conv.in_phase;
			if (conv.in_over) begin
				st_next.word = OFD_OVER_WORD;
			end else if (conv.in_under) begin
				st_next.word = OFD_UNDER_WORD;
			end else begin
				// Sign extension keeps zero at code zero, one step per LSB
				st_next.word = {{2{conv.in_code[OFD_CODE_W-1]}}, conv.in_code};
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign conv.out_valid = st_reg.valid;
	assign conv.out_phase = st_reg.phase;
	assign conv.out_word = st_reg.word;

endmodule

// ==== core/ofd_top.sv ====
// What this block does
// - Four offset settings, active phase's one applied
// - Per-phase magnitude sets cancellation current
// - Per-phase polarity selects add or subtract
// - Polarity one means negative, subtracted current
// - 22-bit code becomes 24-bit twos complement
// - Zero input gives zero, full scale extremes
// - In range, top two bits copy sign
// - Bits 23..21 flag range and overflow
// - Phase order LED2, ambient2 or LED3, LED1, ambient1
// - Four results, each in its own register
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module ofd_top (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [ofd_pkg::OFD_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ofd_pkg::OFD_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ofd_pkg::OFD_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [ofd_pkg::OFD_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cycle_start,
	input wire logic phase_advance,
	input wire logic conv_done,
	input wire logic [1:0] conv_phase,
	input wire logic [ofd_pkg::OFD_CODE_W-1:0] conv_code,
	input wire logic conv_over,
	input wire logic conv_under,
	output logic [ofd_pkg::OFD_MAG_W-1:0] offset_cancel_magnitude,
	output logic offset_cancel_polarity,
	output ofd_pkg::ofd_kind_t phase_kind,
	output logic irq
);
	import ofd_pkg::*;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic aw_held;
		logic [OFD_ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [OFD_DATA_W-1:0] w_data;
		logic [3:0] w_strb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [OFD_DATA_W-1:0] rdata;
		logic three_led;
		logic [OFD_PHASES-1:0][OFD_MAG_W-1:0] mag;
		logic [OFD_PHASES-1:0] pol;
		logic [OFD_PHASES-1:0][OFD_WORD_W-1:0] result;
		logic [OFD_EVT_W-1:0] int_status;
		logic [OFD_EVT_W-1:0] int_enable;
		logic [OFD_CNT_W-1:0] cycles;
		logic irq;
		ofd_phase_t phase;
		logic [OFD_MAG_W-1:0] dac_mag;
		logic dac_pol;
		ofd_kind_t kind;
	} ofd_top_state_t;

	ofd_top_state_t st_reg;
	ofd_top_state_t st_next;

	ofd_conv_if conv_bus ();

	assign conv_bus.in_valid = conv_done;
	assign conv_bus.in_phase = conv_phase;
	assign conv_bus.in_code = conv_code;
	assign conv_bus.in_over = conv_over;
	assign conv_bus.in_under = conv_under;

	ofd_fmt u_fmt (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.conv(conv_bus.fmt)
	);

	// Decode of a register address; shared by the read and write paths
	function automatic logic ofd_decode(
		input logic [OFD_ADDR_W-1:0] addr,
		output ofd_sel_t sel
	);
		logic hit;
		hit = 1'b1;
		sel = OFD_SEL_CTRL;
		if (addr[1:0] != 2'h0) begin
			hit = 1'b0;
		end else if (addr == OFD_CTRL_OFS) begin
			sel = OFD_SEL_CTRL;
		end else if (addr == OFD_STATUS_OFS) begin
			sel = OFD_SEL_STATUS;
		end else if (addr == OFD_INT_STATUS_OFS) begin
			sel = OFD_SEL_ISTAT;
		end else if (addr == OFD_INT_CLEAR_OFS) begin
			sel = OFD_SEL_ICLR;
		end else if (addr == OFD_INT_ENABLE_OFS) begin
			sel = OFD_SEL_IEN;
		end else if (addr == OFD_CYCLES_OFS) begin
			sel = OFD_SEL_CYCLES;
		end else if (addr[7:4] == OFD_OFFSET_PAGE) begin
			sel = OFD_SEL_OFFSET;
		end else if (addr[7:4] == OFD_RESULT_PAGE) begin
			sel = OFD_SEL_RESULT;
		end else begin
			hit = 1'b0;
		end
		return hit;
	endfunction

	// Byte-lane merge of a write into an old register value
	function automatic logic [OFD_DATA_W-1:0] ofd_merge(
		input logic [OFD_DATA_W-1:0] old_val,
		input logic [OFD_DATA_W-1:0] new_val,
		input logic [3:0] strb
	);
		logic [OFD_DATA_W-1:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Slot index of each sampling phase, used for settings and the status phase field
	function automatic logic [1:0] ofd_slot(input ofd_phase_t ph);
		logic [1:0] idx;
		case (ph)
			OFD_PH_LED2: idx = 2'h0;
			OFD_PH_MID: idx = 2'h1;
			OFD_PH_LED1: idx = 2'h2;
			default: idx = 2'h3;
		endcase
		return idx;
	endfunction

	logic wr_hit;
	logic rd_hit;
	ofd_sel_t wr_sel;
	ofd_sel_t rd_sel;
	logic [1:0] wr_idx;
	logic [1:0] rd_idx;
	logic [OFD_DATA_W-1:0] ofs_word [OFD_PHASES];
	logic [OFD_DATA_W-1:0] rd_value;
	logic [OFD_EVT_W-1:0] events;
	logic [OFD_EVT_W-1:0] clear_bits;
	logic do_write;

	// The decode returns its select through an argument, so it is called procedurally
	always_comb begin
		wr_hit = ofd_decode(st_reg.aw_addr, wr_sel);
	end
	always_comb begin
		rd_hit = ofd_decode(s_axi_araddr, rd_sel);
	end
	assign wr_idx = st_reg.aw_addr[3:2];
	assign rd_idx = s_axi_araddr[3:2];
	assign do_write = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;

	genvar g;
	generate
		for (g = 0; g < OFD_PHASES; g++) begin : g_ofs
			// Offset register image: magnitude low, polarity above it
			always_comb begin
				ofs_word[g] = '0;
				ofs_word[g][OFD_OFS_MAG_LSB +: OFD_MAG_W] = st_reg.mag[g];
				ofs_word[g][OFD_OFS_POL_BIT] = st_reg.pol[g];
			end
		end
	endgenerate

	// Read data multiplexer
	always_comb begin
		rd_value = '0;
		case (rd_sel)
			OFD_SEL_CTRL: rd_value[OFD_CTRL_THREE_LED_BIT] = st_reg.three_led;
			OFD_SEL_STATUS: begin
				rd_value[OFD_STATUS_PHASE_LSB +: 2] = ofd_slot(st_reg.phase);
				rd_value[OFD_STATUS_KIND_LSB +: 3] = st_reg.kind;
				rd_value[OFD_STATUS_MODE_BIT] = st_reg.three_led;
			end
			OFD_SEL_ISTAT: rd_value[OFD_EVT_W-1:0] = st_reg.int_status;
			OFD_SEL_IEN: rd_value[OFD_EVT_W-1:0] = st_reg.int_enable;
			OFD_SEL_CYCLES: rd_value[OFD_CNT_W-1:0] = st_reg.cycles;
			OFD_SEL_OFFSET: rd_value = ofs_word[rd_idx];
			OFD_SEL_RESULT: rd_value[OFD_WORD_W-1:0] = st_reg.result[rd_idx];
			default: rd_value = '0;
		endcase
		if (!rd_hit) begin
			rd_value = '0;
		end
	end

	// Events raised by a finished conversion word
	always_comb begin
		events = '0;
		if (conv_bus.out_valid) begin
			events[OFD_EVT_RES_LSB + conv_bus.out_phase] = 1'b1;
			events[OFD_EVT_OVER_BIT] =
				conv_bus.out_word[OFD_RANGE_LSB +: 3] == OFD_RANGE_OVER;
			events[OFD_EVT_UNDER_BIT] =
				conv_bus.out_word[OFD_RANGE_LSB +: 3] == OFD_RANGE_UNDER;
		end
	end

	always_comb begin
		logic [OFD_DATA_W-1:0] merged;
		merged = '0;
		clear_bits = '0;
		st_next = st_reg;

		// Write address and data channels, taken in either order
		if (s_axi_awvalid && st_reg.awready) begin
			st_next.aw_held = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_reg.wready) begin
			st_next.w_held = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end

		if (do_write) begin
			st_next.aw_held = 1'b0;
			st_next.w_held = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = wr_hit ? OFD_RESP_OKAY : OFD_RESP_SLVERR;
			if (wr_hit) begin
				case (wr_sel)
					OFD_SEL_CTRL: begin
						merged = ofd_merge({31'h0, st_reg.three_led}, st_reg.w_data,
							st_reg.w_strb);
						st_next.three_led = merged[OFD_CTRL_THREE_LED_BIT];
					end
					OFD_SEL_ICLR: begin
						merged = ofd_merge('0, st_reg.w_data, st_reg.w_strb);
						clear_bits = merged[OFD_EVT_W-1:0];
					end
					OFD_SEL_IEN: begin
						merged = ofd_merge({26'h0, st_reg.int_enable}, st_reg.w_data,
							st_reg.w_strb);
						st_next.int_enable = merged[OFD_EVT_W-1:0];
					end
					OFD_SEL_OFFSET: begin
						merged = ofd_merge(ofs_word[wr_idx], st_reg.w_data, st_reg.w_strb);
						st_next.mag[wr_idx] = merged[OFD_OFS_MAG_LSB +: OFD_MAG_W];
						st_next.pol[wr_idx] = merged[OFD_OFS_POL_BIT];
					end
					default: merged = '0;
				endcase
			end
		end

		// One read at a time; the answer comes the cycle after the address
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_reg.arready) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = rd_value;
			st_next.rresp = rd_hit ? OFD_RESP_OKAY : OFD_RESP_SLVERR;
		end
		st_next.arready = !st_next.rvalid;
		st_next.awready = !st_next.aw_held && !st_next.bvalid;
		st_next.wready = !st_next.w_held && !st_next.bvalid;

		// A result register changes only when its own word completes
		if (conv_bus.out_valid) begin
			st_next.result[conv_bus.out_phase] = conv_bus.out_word;
		end

		// A new event wins over a clear in the same cycle
		st_next.int_status = (st_reg.int_status & ~clear_bits) | events;
		st_next.irq = |(st_next.int_status & st_next.int_enable);

		// Phase sequencer driven by the timing engine strobes
		if (cycle_start) begin
			st_next.phase = OFD_PH_LED2;
			st_next.cycles = st_reg.cycles + 16'h0001;
		end else if (phase_advance) begin
			case (st_reg.phase)
				OFD_PH_LED2: st_next.phase = OFD_PH_MID;
				OFD_PH_MID: st_next.phase = OFD_PH_LED1;
				OFD_PH_LED1: st_next.phase = OFD_PH_AMB1;
				default: st_next.phase = OFD_PH_LED2;
			endcase
		end

		case (st_next.phase)
			OFD_PH_LED2: st_next.kind = OFD_KIND_LED2;
			OFD_PH_MID: st_next.kind = st_next.three_led ? OFD_KIND_LED3 : OFD_KIND_AMB2;
			OFD_PH_LED1: st_next.kind = OFD_KIND_LED1;
			default: st_next.kind = OFD_KIND_AMB1;
		endcase

		// Setting of the active phase goes to the cancellation current source
		st_next.dac_mag = st_next.mag[ofd_slot(st_next.phase)];
		st_next.dac_pol = st_next.pol[ofd_slot(st_next.phase)];
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_reg <= '0;
			st_reg.awready <= 1'b1;
			st_reg.wready <= 1'b1;
			st_reg.arready <= 1'b1;
			st_reg.phase <= OFD_PH_LED2;
			st_reg.kind <= OFD_KIND_LED2;
			st_reg.int_status <= OFD_EVT_RST;
			st_reg.int_enable <= OFD_EVT_RST;
			st_reg.cycles <= OFD_CNT_RST;
			st_reg.dac_mag <= OFD_MAG_RST;
			st_reg.dac_pol <= OFD_POL_RST;
			for (int i = 0; i < OFD_PHASES; i++) begin
				st_reg.mag[i] <= OFD_MAG_RST;
				st_reg.pol[i] <= OFD_POL_RST;
				st_reg.result[i] <= OFD_RESULT_RST;
			end
		end else begin
			st_reg <= st_next;
		end
	end

	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready = st_reg.wready;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign offset_cancel_magnitude = st_reg.dac_mag;
	assign offset_cancel_polarity = st_reg.dac_pol;
	assign phase_kind = st_reg.kind;
	assign irq = st_reg.irq;

endmodule

// ==== verification/ofd_top_sva.sv ====
`timescale 1ns/1ps
module ofd_top_sva (
	input logic clk_sys,
	input logic reset_n,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [ofd_pkg::OFD_DATA_W-1:0] s_axi_rdata,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic cycle_start,
	input logic phase_advance,
	input logic conv_done,
	input logic [ofd_pkg::OFD_MAG_W-1:0] offset_cancel_magnitude,
	input logic offset_cancel_polarity,
	input ofd_pkg::ofd_kind_t phase_kind,
	input logic irq
);
	import ofd_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	a_reset_vals: assert property (disable iff (1'b0) !reset_n |=>
		offset_cancel_magnitude == OFD_MAG_RST && offset_cancel_polarity == OFD_POL_RST
		&& phase_kind == OFD_KIND_LED2 && !irq && !s_axi_bvalid && !s_axi_rvalid)
		else $error("reset values wrong");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write answer late");
	a_cycle_led2: assert property (cycle_start |=> phase_kind == OFD_KIND_LED2)
		else $error("cycle start not at first phase");
	a_led2_mid: assert property (phase_advance && !cycle_start && phase_kind == OFD_KIND_LED2
		|=> phase_kind inside {OFD_KIND_AMB2, OFD_KIND_LED3}) else $error("second phase wrong");
	a_led1_amb1: assert property (phase_advance && !cycle_start && phase_kind == OFD_KIND_LED1
		|=> phase_kind == OFD_KIND_AMB1) else $error("fourth phase wrong");
	a_phase_wrap: assert property (phase_advance && !cycle_start && phase_kind == OFD_KIND_AMB1
		|=> phase_kind == OFD_KIND_LED2) else $error("phase wrap wrong");

	c_irq: cover property (conv_done ##2 irq);
	c_led3: cover property (phase_kind == OFD_KIND_LED3);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == OFD_RESP_SLVERR);
endmodule

bind ofd_top ofd_top_sva u_sva (.clk_sys, .reset_n, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .cycle_start, .phase_advance,
	.conv_done, .offset_cancel_magnitude, .offset_cancel_polarity, .phase_kind, .irq);

// ==== verification/ofd_host_model.sv ====
`timescale 1ns/1ps
module ofd_host_model (
	input logic clk_sys,
	output logic [ofd_pkg::OFD_ADDR_W-1:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input logic s_axi_awready,
	output logic [ofd_pkg::OFD_DATA_W-1:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [ofd_pkg::OFD_ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [ofd_pkg::OFD_DATA_W-1:0] s_axi_rdata,
	input logic [1:0] s_axi_rresp,
	input logic s_axi_rvalid,
	output logic s_axi_rready
);
	import ofd_pkg::*;
	initial begin
		s_axi_awaddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_araddr = 8'h00;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
	end

	// Released lines show the inverse so stale values are never mistaken for live ones
	task automatic wr(input logic [OFD_ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw = 1'b0;
		logic w = 1'b0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
			// Ready trails valid by a cycle so the response must be seen held
			if (s_axi_bvalid && !s_axi_bready) begin
				s_axi_bready <= 1'b1;
			end
		end while (!(s_axi_bvalid && s_axi_bready));
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [OFD_ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar = 1'b0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (!ar && s_axi_arready) begin
				ar = 1'b1;
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
			if (s_axi_rvalid && !s_axi_rready) begin
				s_axi_rready <= 1'b1;
			end
		end while (!(s_axi_rvalid && s_axi_rready));
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// ==== verification/ofd_top_tb.sv ====
`timescale 1ns/1ps
module ofd_top_tb;
	import ofd_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [OFD_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [OFD_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic cycle_start = 1'b0;
	logic phase_advance = 1'b0;
	logic conv_done = 1'b0;
	logic conv_over = 1'b0;
	logic conv_under = 1'b0;
	logic [1:0] conv_phase = 2'h0;
	logic [OFD_CODE_W-1:0] conv_code = 22'h000000;
	logic [OFD_MAG_W-1:0] offset_cancel_magnitude;
	logic offset_cancel_polarity, irq;
	ofd_kind_t phase_kind;
	int mismatches = 0;
	int cmp_count = 0;
	logic [31:0] d;
	logic [1:0] r;

	always #2.5 clk_sys = ~clk_sys;

	ofd_top uut (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .cycle_start, .phase_advance, .conv_done, .conv_phase, .conv_code,
		.conv_over, .conv_under, .offset_cancel_magnitude, .offset_cancel_polarity, .phase_kind,
		.irq);
	ofd_host_model host (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic step(input logic s);
		@(posedge clk_sys);
		cycle_start <= s;
		phase_advance <= !s;
		@(posedge clk_sys);
		cycle_start <= 1'b0;
		phase_advance <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic conv(input logic [1:0] p, input logic [21:0] c, input logic o, input logic u);
		@(posedge clk_sys);
		conv_done <= 1'b1;
		conv_phase <= p;
		conv_code <= c;
		conv_over <= o;
		conv_under <= u;
		@(posedge clk_sys);
		conv_done <= 1'b0;
		conv_code <= ~c;
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic t_reset;
		for (int i = 0; i < 4; i++) begin
			host.rd({OFD_OFFSET_PAGE, 2'(i), 2'h0}, d, r);
			chk("offset", d, 32'h00000000);
			host.rd({OFD_RESULT_PAGE, 2'(i), 2'h0}, d, r);
			chk("result", d, 32'h00000000);
		end
		chk("mag", 32'(offset_cancel_magnitude), 32'h00000000);
		$display("test reset done");
	endtask

	task automatic t_phases;
		ofd_kind_t k[4] = '{OFD_KIND_LED2, OFD_KIND_AMB2, OFD_KIND_LED1, OFD_KIND_AMB1};
		for (int i = 0; i < 4; i++)
			host.wr({OFD_OFFSET_PAGE, 2'(i), 2'h0}, {23'h000000, !i[0], 4'h0, 4'(5 + 3 * i)}, r);
		for (int i = 0; i <= 4; i++) begin
			step(i == 0);
			chk("kind", 32'(phase_kind), 32'(k[i % 4]));
			chk("mag", 32'(offset_cancel_magnitude), 32'(5 + 3 * (i % 4)));
			chk("pol", 32'(offset_cancel_polarity), 32'(i % 2 == 0));
		end
		host.wr(OFD_CTRL_OFS, 32'h00000001, r);
		step(1'b1);
		step(1'b0);
		chk("kind3", 32'(phase_kind), 32'(OFD_KIND_LED3));
		// Slot 1, LED3 kind in bits 6..4, three-LED mode in bit 8
		host.rd(OFD_STATUS_OFS, d, r);
		chk("status", d, 32'h00000121);
		host.wr(OFD_CTRL_OFS, 32'h00000000, r);
		$display("test phases done");
	endtask

	task automatic t_convert;
		logic [21:0] c[6] = '{22'h1FFFFF, 22'h200000, 22'h000000, 22'h000000, 22'h000000,
			22'h3FFFFF};
		// Words expected for each code; the last two zeros are sent out of range
		logic [23:0] w[6] = '{24'h1FFFFF, 24'hE00000, 24'h000000, 24'h3FFFFF, 24'hC00000,
			24'hFFFFFF};
		logic o;
		logic u;
		host.wr(OFD_INT_ENABLE_OFS, 32'h0000003F, r);
		for (int i = 0; i < 6; i++) begin
			o = (i == 3);
			u = (i == 4);
			conv(2'(i), c[i], o, u);
			host.rd({OFD_RESULT_PAGE, 2'(i), 2'h0}, d, r);
			chk("word", d, {8'h00, w[i]});
			host.rd(OFD_INT_STATUS_OFS, d, r);
			chk("istat", d, {26'h0, u, o, 4'h1 << 2'(i)});
			chk("irq", 32'(irq), 32'h00000001);
			host.wr(OFD_INT_CLEAR_OFS, 32'h0000003F, r);
			repeat (2) @(posedge clk_sys);
			chk("irq_clr", 32'(irq), 32'h00000000);
		end
		host.rd({OFD_RESULT_PAGE, 2'h3, 2'h0}, d, r);
		chk("keep", d, {8'h00, OFD_OVER_WORD});
		host.wr(OFD_INT_ENABLE_OFS, 32'h00000000, r);
		conv(2'h2, 22'h000123, 1'b0, 1'b0);
		chk("irq_mask", 32'(irq), 32'h00000000);
		host.rd(OFD_INT_STATUS_OFS, d, r);
		chk("istat_mask", d, 32'h00000004);
		host.wr(OFD_INT_CLEAR_OFS, 32'h0000003F, r);
		$display("test convert done");
	endtask

	task automatic t_bus;
		host.rd(8'hFC, d, r);
		chk("rresp", 32'(r), 32'(OFD_RESP_SLVERR));
		chk("rdata", d, 32'h00000000);
		host.rd(8'h22, d, r);
		chk("unaligned", 32'(r), 32'(OFD_RESP_SLVERR));
		host.wr(8'hFC, 32'h00000001, r);
		chk("bresp", 32'(r), 32'(OFD_RESP_SLVERR));
		host.wr({OFD_RESULT_PAGE, 4'h0}, 32'h00000123, r);
		chk("bresp_ro", 32'(r), 32'(OFD_RESP_OKAY));
		host.rd({OFD_RESULT_PAGE, 4'h0}, d, r);
		chk("ro", d, {8'h00, OFD_UNDER_WORD});
		host.rd(OFD_INT_CLEAR_OFS, d, r);
		chk("iclr", d, 32'h00000000);
		host.rd(OFD_CYCLES_OFS, d, r);
		chk("cycles", d, 32'h00000002);
		$display("test bus done");
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_reset;
		t_phases;
		t_convert;
		t_bus;
		give_verdict;
	end

	initial begin
		#200000;
		mismatches++;
		give_verdict;
	end
endmodule
